// ---- rtl/cpa_codec_power.sv ----
// Summary of operation
// - reset clears logic, powers down, clamps outputs
// - stay in reset while reset pin low
// - capture address 2 ms plus 3000 clocks later
// - ignore control accesses until address captured
// - count clocks per frame for ratio
// - power up and unclamp when any converter enabled and the ratio is known
// - four states: reset, address wait, power-down, running
// - first channel msb on second bit clock rise
// - data out changes after bit clock fall
// - data in sampled on bit clock rise
`timescale 1ns/1ps
`default_nettype none
module cpa_codec_power
    import cpa_pkg::*;
#(
    parameter int ADDR_WAIT = ADDR_WAIT_CYC
) (
    // clock and reset pin
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    // axi4-lite write data
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // axi4-lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // serial audio port pins
    input wire logic bit_clock,
    input wire logic frame_sync,
    input wire logic serial_data_in,
    output logic serial_data_out,
    // address select straps and captured address
    input wire logic [1:0] addr_select,
    output logic [1:0] control_addr,
    output logic control_port_ready,
    // analog controls
    output logic outputs_clamped,
    output logic reference_enable,
    output logic [3:0] converter_enable,
    output logic mute_active,
    output logic supply_level_select,
    output logic quiescent_discharge_ramp
);
    cpa_ctrl_t ctrl; // software control bits
    cpa_state_t state; // sequencer state
    logic [16:0] wait_cnt; // address capture delay
    logic [31:0] tx_word; // word sent in first slot
    logic [31:0] rx_word; // last first-slot word received
    logic [31:0] rx_shift; // incoming bits
    logic [11:0] meas_cnt; // clocks since last frame sync rise
    logic [11:0] ratio; // measured clocks per frame
    logic meas_armed; // one frame sync rise seen
    logic ratio_done; // measurement complete
    logic [9:0] bit_cnt; // bit clock rises since frame start
    logic fs_at_bclk; // frame sync at previous bit clock rise
    logic [1:0] bclk_s, fs_s, sdin_s; // two-stage synchronisers
    logic [1:0] addr_s0, addr_s1;
    logic bclk_d, fs_d; // third stage for edge finding
    logic bclk_rise, bclk_fall, fs_rise;
    logic aw_held, w_held; // write channels taken
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic any_on; // at least one converter enabled
    logic ratio_valid; // ratio known and not being dropped this cycle

    // register read decode
    function automatic logic [31:0] reg_read(input logic [7:0] a);
        case (a)
            OFS_CTRL: reg_read = {26'h0, ctrl};
            OFS_TX: reg_read = tx_word;
            OFS_STATUS: reg_read = {25'h0, control_addr, mute_active, ratio_done,
                control_port_ready, state};
            OFS_RATIO: reg_read = {20'h0, ratio};
            OFS_RX: reg_read = rx_word;
            default: reg_read = 32'h0000_0000;
        endcase
    endfunction

    // mapped address check
    function automatic logic reg_hit(input logic [7:0] a);
        reg_hit = (a == OFS_CTRL) || (a == OFS_TX) || (a == OFS_STATUS) ||
            (a == OFS_RATIO) || (a == OFS_RX);
    endfunction

    // byte-lane merge for writes
    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                          input logic [3:0] s);
        for (int i = 0; i < 4; i++) begin
            merge[i*8 +: 8] = s[i] ? d[i*8 +: 8] : o[i*8 +: 8];
        end
    endfunction

    // pins from outside pass two flip-flops
    always_ff @(posedge aclk) begin
        bclk_s <= {bclk_s[0], bit_clock};
        fs_s <= {fs_s[0], frame_sync};
        sdin_s <= {sdin_s[0], serial_data_in};
        addr_s0 <= addr_select;
        addr_s1 <= addr_s0;
        bclk_d <= bclk_s[1];
        fs_d <= fs_s[1];
    end

    assign bclk_rise = bclk_s[1] && !bclk_d;
    assign bclk_fall = !bclk_s[1] && bclk_d;
    assign fs_rise = fs_s[1] && !fs_d;
    assign any_on = !(&ctrl.converter_power_down);
    // leave running in the same cycle that the measurement is lost, so no unclamped gap
    assign ratio_valid = ratio_done && !(meas_cnt == FS_TIMEOUT && !fs_rise);

    // sequencer: reset, address wait, power-down, running
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= ST_RESET;
            wait_cnt <= 17'h0_0000;
        end else begin
            case (state)
                ST_RESET: begin
                    state <= ST_ADDR_WAIT;
                    wait_cnt <= 17'h0_0000;
                end
                ST_ADDR_WAIT: begin
                    if (wait_cnt == 17'(ADDR_WAIT - 1)) begin
                        state <= ST_POWER_DOWN;
                    end else begin
                        wait_cnt <= wait_cnt + 17'h0_0001;
                    end
                end
                ST_POWER_DOWN: begin
                    if (any_on && ratio_valid) begin
                        state <= ST_RUNNING;
                    end
                end
                ST_RUNNING: begin
                    if (!any_on || !ratio_valid) begin
                        state <= ST_POWER_DOWN;
                    end
                end
                default: state <= ST_RESET;
            endcase
        end
    end

    // address capture at end of wait
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            control_addr <= 2'h0;
            control_port_ready <= 1'b0;
        end else if (state == ST_ADDR_WAIT && wait_cnt == 17'(ADDR_WAIT - 1)) begin
            control_addr <= addr_s1;
            control_port_ready <= 1'b1;
        end
    end

    // analog controls follow the state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            outputs_clamped <= 1'b1;
            reference_enable <= 1'b0;
            converter_enable <= 4'h0;
        end else begin
            outputs_clamped <= (state != ST_RUNNING);
            reference_enable <= (state == ST_RUNNING);
            converter_enable <= (state == ST_RUNNING) ? ~ctrl.converter_power_down : 4'h0;
        end
    end

    // ratio measurement over one frame
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meas_cnt <= 12'h000;
            ratio <= 12'h000;
            meas_armed <= 1'b0;
            ratio_done <= 1'b0;
        end else if (fs_rise) begin
            meas_cnt <= 12'h001;
            meas_armed <= 1'b1;
            if (meas_armed) begin
                ratio <= meas_cnt;
                ratio_done <= 1'b1;
            end
        end else if (meas_cnt == FS_TIMEOUT) begin
            meas_armed <= 1'b0;
            ratio_done <= 1'b0;
        end else begin
            meas_cnt <= meas_cnt + 12'h001;
        end
    end

    // mute on clocking change while converters on
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mute_active <= 1'b0;
        end else if (fs_rise && meas_armed && ratio_done && any_on && meas_cnt != ratio) begin
            mute_active <= 1'b1;
        end else if (!any_on) begin
            mute_active <= 1'b0;
        end
    end

    // bit position in the frame
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bit_cnt <= 10'h000;
            fs_at_bclk <= 1'b0;
        end else if (bclk_rise) begin
            fs_at_bclk <= fs_s[1];
            // first rise after frame sync is one
            if (fs_s[1] && !fs_at_bclk) begin
                bit_cnt <= SLOT_FIRST;
            end else if (bit_cnt != BIT_CNT_MAX) begin
                bit_cnt <= bit_cnt + 10'h001;
            end
        end
    end

    // receive first slot
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_shift <= 32'h0000_0000;
            rx_word <= 32'h0000_0000;
        end else if (bclk_rise && !(fs_s[1] && !fs_at_bclk) &&
                     bit_cnt >= SLOT_FIRST && bit_cnt <= SLOT_LAST) begin
            rx_shift <= {rx_shift[30:0], sdin_s[1]};
            if (bit_cnt == SLOT_LAST) begin
                rx_word <= {rx_shift[30:0], sdin_s[1]};
            end
        end
    end

    // transmit first slot
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            serial_data_out <= 1'b0;
        end else if (bclk_fall) begin
            if (state == ST_RUNNING && !mute_active &&
                bit_cnt >= SLOT_FIRST && bit_cnt <= SLOT_LAST) begin
                serial_data_out <= tx_word[5'(SLOT_LAST - bit_cnt)];
            end else begin
                serial_data_out <= 1'b0;
            end
        end
    end

    // axi write channel holding
    assign awready = !aw_held && !bvalid;
    assign wready = !w_held && !bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (aw_held && w_held) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
        end else begin
            if (awvalid && awready) begin
                aw_held <= 1'b1;
                aw_addr <= awaddr;
            end
            if (wvalid && wready) begin
                w_held <= 1'b1;
                w_data <= wdata;
                w_strb <= wstrb;
            end
        end
    end

    // register writes and write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= '{quiescent_discharge_ramp: 1'b0, supply_level_select: 1'b0,
                      converter_power_down: PDN_RESET};
            tx_word <= TX_RESET;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else if (aw_held && w_held) begin
            bvalid <= 1'b1;
            if (!control_port_ready || !reg_hit(aw_addr)) begin
                bresp <= RESP_SLVERR;
            end else begin
                bresp <= RESP_OKAY;
                if (aw_addr == OFS_CTRL) begin
                    ctrl <= cpa_ctrl_t'(6'(merge({26'h0, ctrl}, w_data, w_strb)));
                end else if (aw_addr == OFS_TX) begin
                    tx_word <= merge(tx_word, w_data, w_strb);
                end
            end
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    assign supply_level_select = ctrl.supply_level_select;
    assign quiescent_discharge_ramp = ctrl.quiescent_discharge_ramp;

    // read channel
    assign arready = !rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            if (!control_port_ready || !reg_hit(araddr)) begin
                rdata <= 32'h0000_0000;
                rresp <= RESP_SLVERR;
            end else begin
                rdata <= reg_read(araddr);
                rresp <= RESP_OKAY;
            end
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // checks
    default clocking chk_clk @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // the reset checks must not be switched off by the default reset
    reset_clamp_a: assert property (@(posedge aclk) disable iff (1'b0)
        !aresetn |=> outputs_clamped && !reference_enable)
        else $error("outputs not clamped after reset");
    reset_hold_a: assert property (@(posedge aclk) disable iff (1'b0)
        !aresetn |=> state == ST_RESET)
        else $error("left reset while pin low");
    addr_wait_a: assert property ($rose(control_port_ready) |->
        $past(wait_cnt) == 17'(ADDR_WAIT - 1))
        else $error("address captured at wrong time");
    early_access_a: assert property (!control_port_ready && aw_held && w_held |=>
        bresp == RESP_SLVERR && $stable(ctrl))
        else $error("write accepted before address capture");
    ratio_meas_a: assert property (fs_rise && meas_armed |=>
        ratio_done && ratio == $past(meas_cnt))
        else $error("ratio not taken from frame count");
    run_power_a: assert property (state == ST_RUNNING |=>
        !outputs_clamped && reference_enable)
        else $error("running without power up");
    power_down_a: assert property (state == ST_RUNNING && !any_on |=> state == ST_POWER_DOWN)
        else $error("all converters off but still running");
    frame_align_a: assert property (bclk_rise && fs_s[1] && !fs_at_bclk |=>
        bit_cnt == SLOT_FIRST)
        else $error("frame start misaligned");
    out_edge_a: assert property ($changed(serial_data_out) |-> $past(bclk_fall))
        else $error("data out changed off falling edge");
    in_sample_a: assert property (bclk_rise && bit_cnt == SLOT_FIRST && !fs_s[1] |=>
        rx_shift[0] == $past(sdin_s[1]))
        else $error("data in not sampled on rise");
    clamp_meas_a: assert property (!ratio_done |=> outputs_clamped)
        else $error("unclamped without ratio");

    cov_ready_c: cover property ($rose(control_port_ready));
    cov_running_c: cover property (state == ST_RUNNING);
    cov_mute_c: cover property ($rose(mute_active));
    cov_rx_c: cover property (bclk_rise && bit_cnt == SLOT_LAST);
endmodule
`default_nettype wire

// ---- rtl/cpa_pkg.sv ----
package cpa_pkg;
    // clock rate and the address capture delay after reset release
    localparam int CLK_KHZ = 25000;
    localparam int ADDR_WAIT_US = 2000;
    localparam int ADDR_WAIT_MCLK = 3000;
    localparam int ADDR_WAIT_CYC = ADDR_WAIT_US * CLK_KHZ / 1000 + ADDR_WAIT_MCLK;
    // frame sync considered lost after this many cycles without a rising edge
    localparam logic [11:0] FS_TIMEOUT = 12'h0_FFF;
    // bit positions in the frame: first slot, 32 bits wide
    localparam logic [9:0] SLOT_FIRST = 10'h0_01;
    localparam logic [9:0] SLOT_LAST = 10'h0_20;
    localparam logic [9:0] BIT_CNT_MAX = 10'h3_FF;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_TX = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_RATIO = 8'h0C;
    localparam logic [7:0] OFS_RX = 8'h10;
    // reset values
    localparam logic [3:0] PDN_RESET = 4'h0_F;
    localparam logic [31:0] TX_RESET = 32'h0000_0000;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // control register fields
    typedef struct packed {
        logic quiescent_discharge_ramp;
        logic supply_level_select;
        logic [3:0] converter_power_down;
    } cpa_ctrl_t;

    // sequencer states
    typedef enum logic [1:0] {
        ST_RESET,
        ST_ADDR_WAIT,
        ST_POWER_DOWN,
        ST_RUNNING
    } cpa_state_t;
endpackage

// ---- sim/codec_powerup_and_audio_clocking_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module codec_powerup_and_audio_clocking_tb;
    import cpa_pkg::*;
    localparam int WAIT_CYC = 20; // shortened capture delay
    localparam logic [31:0] TX_WORD = 32'hA5C3_0F96;
    // one table row: access and expected answers
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic [1:0] wr_resp;
        logic [1:0] rd_resp;
        logic [31:0] rd_data;
    } cpa_row_t;
    cpa_row_t rows [3];
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, send_word, got_word, rd;
    logic [3:0] wstrb, converter_enable;
    logic [1:0] bresp, rresp, control_addr, resp, addr_select;
    logic bit_clock, frame_sync, serial_data_in, serial_data_out, control_port_ready;
    logic outputs_clamped, reference_enable, mute_active, supply_level_select;
    logic quiescent_discharge_ramp, run;
    logic [7:0] frame_bits;
    int miscompares, check_count, c0, k;

    cpa_codec_power #(.ADDR_WAIT(WAIT_CYC)) cpa_codec_power_i (.aclk, .aresetn, .awaddr,
        .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
        .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .bit_clock,
        .frame_sync, .serial_data_in, .serial_data_out, .addr_select, .control_addr,
        .control_port_ready, .outputs_clamped, .reference_enable, .converter_enable,
        .mute_active, .supply_level_select, .quiescent_discharge_ramp);
    cpa_host_model cpa_host_model_i (.bit_clock, .frame_sync, .serial_data_in,
        .serial_data_out, .run, .frame_bits, .send_word, .got_word);

    always #20 aclk = ~aclk;

    // compare and count
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // verdict and end of run
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // a wait that ran out ends the run
    task automatic give_up(input string what);
        miscompares++;
        $display("mismatch %s expected answer seen timeout", what);
        tally_and_finish();
    endtask

    // one write: values seen at the falling edge are those of the next rise
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ta, tw, tb;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int i = 0; i < 100; i++) begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            r = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) begin
                bready <= 1'b0;
                return;
            end
        end
        give_up("write");
    endtask

    // one read, data taken at the edge that ends it
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, tr;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int i = 0; i < 100; i++) begin
            @(negedge aclk);
            ta = arvalid && arready;
            tr = rvalid;
            r = rresp;
            d = rdata;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
            if (tr) begin
                rready <= 1'b0;
                return;
            end
        end
        give_up("read");
    endtask

    // outputs that must hold while the reset pin is low
    task automatic check_idle;
        chk("reset outputs", 32'h0000_0200, {20'h0, quiescent_discharge_ramp,
            supply_level_select, outputs_clamped, reference_enable, converter_enable,
            control_port_ready, serial_data_out, bvalid, rvalid});
    endtask

    initial begin
        aclk = 1'b0;
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready, run} = 6'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        addr_select = 2'b10;
        wdata = 32'h0000_0000;
        wstrb = 4'hF;
        frame_bits = 8'h40;
        send_word = 32'h5A3C_96E1;
        miscompares = 0;
        check_count = 0;
        rows[0] = {OFS_TX, TX_WORD, RESP_OKAY, RESP_OKAY, TX_WORD};
        rows[1] = {OFS_CTRL, 32'h0000_001F, RESP_OKAY, RESP_OKAY, 32'h0000_001F};
        rows[2] = {8'h40, 32'h1234_5678, RESP_SLVERR, RESP_SLVERR, 32'h0000_0000};
        // reset pin held low for 8 cycles
        repeat (8) @(posedge aclk);
        check_idle();
        aresetn <= 1'b1;
        @(negedge aclk);
        c0 = k;
        // early accesses are refused and change nothing
        axi_write(OFS_CTRL, 32'h0000_0000, resp);
        chk("early write resp", 32'(RESP_SLVERR), 32'(resp));
        axi_read(OFS_CTRL, rd, resp);
        chk("early read resp", 32'(RESP_SLVERR), 32'(resp));
        // count edges until the address is captured
        while (control_port_ready !== 1'b1 && k - c0 < 200) @(negedge aclk);
        chk("capture edges", WAIT_CYC + 1, k - c0);
        chk("control addr", 32'h0000_0002, 32'(control_addr));
        axi_read(OFS_CTRL, rd, resp);
        chk("ctrl after reset", 32'(PDN_RESET), rd);
        for (int i = 0; i < 3; i++) begin
            axi_write(rows[i].addr, rows[i].wdata, resp);
            chk("row write resp", 32'(rows[i].wr_resp), 32'(resp));
            axi_read(rows[i].addr, rd, resp);
            chk("row read resp", 32'(rows[i].rd_resp), 32'(resp));
            chk("row read data", rows[i].rd_data, rd);
        end
        chk("supply level", 32'h0000_0001, 32'(supply_level_select));
        // converters enabled while no ratio is known: outputs stay clamped
        axi_write(OFS_CTRL, 32'h0000_001E, resp);
        repeat (4) @(negedge aclk);
        chk("clamped before ratio", 32'h0000_0001, 32'(outputs_clamped));
        axi_write(OFS_CTRL, 32'h0000_001F, resp);
        // frames start, 64 bits of 320 ns each
        run <= 1'b1;
        rd = 32'h0000_0000;
        for (int i = 0; i < 40 && rd[3] !== 1'b1; i++) begin
            repeat (100) @(posedge aclk);
            axi_read(OFS_STATUS, rd, resp);
        end
        chk("power-down state", 32'h0000_0002, 32'(rd[1:0]));
        axi_read(OFS_RATIO, rd, resp);
        chk("clocks per frame", 32'd512, rd);
        axi_write(OFS_CTRL, 32'h0000_001E, resp);
        repeat (2) @(negedge aclk);
        chk("power up", 32'h0000_0005, {26'h0, converter_enable, outputs_clamped,
            reference_enable});
        axi_read(OFS_STATUS, rd, resp);
        chk("running state", 32'h0000_0003, 32'(rd[1:0]));
        for (int i = 0; i < 4000 && got_word !== TX_WORD; i++) @(negedge aclk);
        chk("slot out", TX_WORD, got_word);
        axi_read(OFS_RX, rd, resp);
        chk("slot in", send_word, rd);
        frame_bits <= 8'h30;
        for (int i = 0; i < 4000 && mute_active !== 1'b1; i++) @(negedge aclk);
        chk("mute set", 32'h0000_0001, 32'(mute_active));
        repeat (40) @(negedge aclk);
        chk("muted data", 32'h0000_0000, 32'(serial_data_out));
        axi_write(OFS_CTRL, 32'h0000_001F, resp);
        repeat (2) @(negedge aclk);
        chk("mute cleared", 32'h0000_0000, 32'(mute_active));
        // ramp bit raised before the reset pin falls, hold shortened
        axi_write(OFS_CTRL, 32'h0000_003F, resp);
        @(negedge aclk);
        chk("ramp bit", 32'h0000_0001, 32'(quiescent_discharge_ramp));
        // second reset in mid-run, with new address straps
        @(posedge aclk);
        aresetn <= 1'b0;
        addr_select <= 2'b01;
        repeat (2) @(posedge aclk);
        @(negedge aclk);
        check_idle();
        @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        c0 = k;
        while (control_port_ready !== 1'b1 && k - c0 < 200) @(negedge aclk);
        chk("capture edges again", WAIT_CYC + 1, k - c0);
        chk("control addr again", 32'h0000_0001, 32'(control_addr));
        tally_and_finish();
    end

    // edge counter for the capture delay
    always @(posedge aclk) begin
        k <= k + 1;
    end
endmodule
`default_nettype wire

// ---- sim/cpa_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module cpa_host_model (
    // serial port pins toward the codec
    output logic bit_clock,
    output logic frame_sync,
    output logic serial_data_in,
    input wire logic serial_data_out,
    // bench controls and observed word
    input wire logic run,
    input wire logic [7:0] frame_bits,
    input wire logic [31:0] send_word,
    output logic [31:0] got_word
);
    logic [31:0] shift; // first slot gathered from the codec
    int n; // bits in the frame under way

    initial begin
        bit_clock = 1'b0;
        frame_sync = 1'b0;
        serial_data_in = 1'b0;
        got_word = 32'h0000_0000;
    end

    // frames back to back while enabled; the clock stands still otherwise
    always begin
        // an unknown run level must idle too, or this loop spins without time
        if (run !== 1'b1) begin
            #40;
        end else begin
            // whole bits per frame, changed only between frames
            n = frame_bits;
            for (int i = 1; i <= n; i++) begin
                #160;
                bit_clock = 1'b0;
                // sync high for one bit, msb meets the second rise
                frame_sync = (i == 1);
                // outside the slot the line toggles rather than holding
                serial_data_in = (i >= 2 && i <= 33) ? send_word[33 - i] : ~serial_data_in;
                #160;
                bit_clock = 1'b1;
                // capture the codec output at the rise
                if (i >= 2 && i <= 33) begin
                    shift[33 - i] = serial_data_out;
                end
            end
            got_word = shift;
        end
    end
endmodule
`default_nettype wire
